//--- logic/xcb_flag_bank.sv
// Sticky status flags: hardware sets, software clears, set wins
`timescale 1ns/1ps
`default_nettype none

module xcb_flag_bank (
   input  wire logic                      ref_clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic [xcb_pkg::FLAG_W-1:0] set_i,
   input  wire logic [xcb_pkg::FLAG_W-1:0] clr_i,
   output logic      [xcb_pkg::FLAG_W-1:0] flags_o
);

   logic [xcb_pkg::FLAG_W-1:0] flags_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~clr_i) | set_i;
      end
   end

   assign flags_o = flags_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_set_wins_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (set_i != '0) |=> ((flags_q & $past(set_i)) == $past(set_i)))
      else $error("set event lost against clear");

   chk_clear_takes: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (clr_i != '0 && set_i == '0) |=> ((flags_q & $past(clr_i)) == '0))
      else $error("flag not cleared");

   cov_set_and_clear: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (set_i != '0) && (clr_i == set_i));

endmodule

`default_nettype wire

//--- logic/xcb_pkg.sv
// Shared constants and types for the capability and operational register bank
package xcb_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int FLAG_W = 4;
   localparam int LVL_W  = 5;

   // ----------------------------------------------------------------
   // Capability space (offsets from the first base window)
   // ----------------------------------------------------------------
   localparam logic [15:0] CAP_LENGTH  = 16'h0020;
   localparam logic [15:0] CAP_DB_OFF  = 16'h0014;
   localparam logic [15:0] CAP_RT_OFF  = 16'h0018;
   localparam logic [31:0] DB_VALUE    = 32'h000005C0;
   localparam logic [31:0] RT_VALUE    = 32'h000004A0;

   // ----------------------------------------------------------------
   // Operational space (offsets from the operational base)
   // ----------------------------------------------------------------
   localparam logic [15:0] OP_CMD      = 16'h0000;
   localparam logic [15:0] OP_STS      = 16'h0004;
   localparam logic [15:0] OP_PAGE     = 16'h0008;
   localparam logic [15:0] OP_NOTE     = 16'h0014;
   localparam logic [15:0] OP_CRCR_LO  = 16'h0018;
   localparam logic [15:0] OP_CRCR_HI  = 16'h001C;
   localparam logic [15:0] OP_DCBA_LO  = 16'h0030;
   localparam logic [15:0] OP_DCBA_HI  = 16'h0034;
   localparam logic [15:0] OP_CONFIG   = 16'h0038;
   localparam logic [15:0] OP_PORT_LO  = 16'h0400;
   localparam logic [15:0] OP_PORT_HI  = 16'h047F;

   // ----------------------------------------------------------------
   // Values, masks and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] PAGE_VALUE    = 32'h00000001;
   localparam logic [31:0] CMD_RESET     = 32'h00000000;
   localparam logic [31:0] CMD_MASK      = 32'h00000F8F;
   localparam logic [31:0] STS_RESET     = 32'h00000801;
   localparam logic [31:0] STS_RC_MASK   = 32'h0000041C;
   localparam logic [31:0] STS_RO_MASK   = 32'h00001B01;
   localparam logic [31:0] NOTE_MASK     = 32'h0000FFFF;
   localparam logic [31:0] CRCR_RW_MASK  = 32'hFFFFFFC7;
   localparam logic [31:0] PTR_LO_MASK   = 32'hFFFFFFC0;
   localparam logic [31:0] HI_MASK       = 32'hFFFFFFFF;
   localparam logic [31:0] CONFIG_MASK   = 32'h000000FF;
   localparam logic [31:0] ZERO_WORD     = 32'h00000000;
   localparam logic [LVL_W-1:0] LVL_RESET = 5'h09;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CRCR_RUN_BIT = 3;
   localparam int STS_HCH_BIT  = 0;
   localparam int STS_HSE_BIT  = 2;
   localparam int STS_EVENT_INTERRUPT_FLAG_BIT = 3;
   localparam int STS_PCD_BIT  = 4;
   localparam int STS_SSS_BIT  = 8;
   localparam int STS_RSS_BIT  = 9;
   localparam int STS_SRE_BIT  = 10;
   localparam int STS_CNR_BIT  = 11;
   localparam int STS_HCE_BIT  = 12;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [3:0]        be;
      logic [DATA_W-1:0] wdata;
   } xcb_req_type;

   typedef struct packed {
      logic save_restore_err_evt;
      logic port_change_evt;
      logic event_int_evt;
      logic system_error_evt;
      logic controller_error;
      logic not_ready;
      logic restore_busy;
      logic save_busy;
      logic halted;
      logic ring_running;
   } xcb_hw_type;

   typedef struct packed {
      logic frame_index_stop_in_u3;
      logic wrap_event_enable;
      logic restore_state_cmd;
      logic save_state_cmd;
      logic light_controller_reset;
      logic system_error_enable;
      logic interrupter_enable_ctl;
      logic controller_full_reset;
      logic run_stop;
   } xcb_cmd_type;

endpackage

//--- logic/xcb_reg_bank.sv
// Capability and operational register bank reached through the first base window
`timescale 1ns/1ps
`default_nettype none

module xcb_reg_bank (
   input  wire logic                      ref_clk_i,
   input  wire logic                      rst_n_i,
   input  wire xcb_pkg::xcb_req_type      bus_req_i,
   input  wire xcb_pkg::xcb_hw_type       hw_i,
   output logic      [xcb_pkg::DATA_W-1:0] rd_data_o,
   output logic                           rd_valid_o,
   output xcb_pkg::xcb_cmd_type           cmd_o,
   output logic      [15:0]               note_en_o,
   output logic      [63:0]               ring_ctl_o,
   output logic      [63:0]               ctx_array_ptr_o,
   output logic      [7:0]                config_o
);

   default clocking chk_clk @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] byte_mask(input logic [3:0] be);
      byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be,
                                         input logic [31:0] mask);
      logic [31:0] m;
      m     = byte_mask(be) & mask;
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   // Operational offsets are relative to base window plus capability length
   function automatic logic op_at(input logic [15:0] addr, input logic [15:0] off);
      op_at = (addr == 16'(xcb_pkg::CAP_LENGTH + off));
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic        [15:0] op_off;
   logic               in_op;
   logic               wr_cmd;
   logic               wr_sts;
   logic               wr_note;
   logic               wr_crcr_lo;
   logic               wr_crcr_hi;
   logic               wr_dcba_lo;
   logic               wr_dcba_hi;
   logic               wr_config;
   logic               port_hit;

   assign in_op    = (bus_req_i.addr >= xcb_pkg::CAP_LENGTH);
   assign op_off   = 16'(bus_req_i.addr - xcb_pkg::CAP_LENGTH);
   assign port_hit = in_op && (op_off >= xcb_pkg::OP_PORT_LO)
                     && (op_off <= xcb_pkg::OP_PORT_HI);

   assign wr_cmd     = bus_req_i.wr && op_at(bus_req_i.addr, xcb_pkg::OP_CMD);
   assign wr_sts     = bus_req_i.wr && op_at(bus_req_i.addr, xcb_pkg::OP_STS);
   assign wr_note    = bus_req_i.wr && op_at(bus_req_i.addr, xcb_pkg::OP_NOTE);
   assign wr_crcr_lo = bus_req_i.wr && op_at(bus_req_i.addr, xcb_pkg::OP_CRCR_LO);
   assign wr_crcr_hi = bus_req_i.wr && op_at(bus_req_i.addr, xcb_pkg::OP_CRCR_HI);
   assign wr_dcba_lo = bus_req_i.wr && op_at(bus_req_i.addr, xcb_pkg::OP_DCBA_LO);
   assign wr_dcba_hi = bus_req_i.wr && op_at(bus_req_i.addr, xcb_pkg::OP_DCBA_HI);
   assign wr_config  = bus_req_i.wr && op_at(bus_req_i.addr, xcb_pkg::OP_CONFIG);

   // ----------------------------------------------------------------
   // Command register
   // ----------------------------------------------------------------
   logic [31:0] cmd_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_q <= xcb_pkg::CMD_RESET;
      end else if (wr_cmd) begin
         // Only defined control bits store; reserved stay zero
         cmd_q <= merge(cmd_q, bus_req_i.wdata, bus_req_i.be, xcb_pkg::CMD_MASK);
      end
   end

   assign cmd_o = {cmd_q[11:7], cmd_q[3:0]};

   // ----------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------
   logic [xcb_pkg::FLAG_W-1:0] flag_set;
   logic [xcb_pkg::FLAG_W-1:0] flag_clr;
   logic [xcb_pkg::FLAG_W-1:0] flags;
   logic [xcb_pkg::LVL_W-1:0]  lvl_q;
   logic [31:0]                sts_word;
   logic [31:0]                clr_word;

   assign flag_set = {hw_i.save_restore_err_evt, hw_i.port_change_evt,
                      hw_i.event_int_evt, hw_i.system_error_evt};
   assign clr_word = wr_sts ? (bus_req_i.wdata & byte_mask(bus_req_i.be)
                               & xcb_pkg::STS_RC_MASK) : xcb_pkg::ZERO_WORD;
   assign flag_clr = {clr_word[xcb_pkg::STS_SRE_BIT], clr_word[xcb_pkg::STS_PCD_BIT],
                      clr_word[xcb_pkg::STS_EVENT_INTERRUPT_FLAG_BIT], clr_word[xcb_pkg::STS_HSE_BIT]};

   xcb_flag_bank u_flags (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .set_i     (flag_set),
      .clr_i     (flag_clr),
      .flags_o   (flags)
   );

   // Read-only state follows the core; writes never reach it
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl_q <= xcb_pkg::LVL_RESET;
      end else begin
         lvl_q <= {hw_i.controller_error, hw_i.not_ready, hw_i.restore_busy,
                   hw_i.save_busy, hw_i.halted};
      end
   end

   always_comb begin
      sts_word                        = xcb_pkg::ZERO_WORD;
      sts_word[xcb_pkg::STS_HCE_BIT]  = lvl_q[4];
      sts_word[xcb_pkg::STS_CNR_BIT]  = lvl_q[3];
      sts_word[xcb_pkg::STS_RSS_BIT]  = lvl_q[2];
      sts_word[xcb_pkg::STS_SSS_BIT]  = lvl_q[1];
      sts_word[xcb_pkg::STS_HCH_BIT]  = lvl_q[0];
      sts_word[xcb_pkg::STS_SRE_BIT]  = flags[3];
      sts_word[xcb_pkg::STS_PCD_BIT]  = flags[2];
      sts_word[xcb_pkg::STS_EVENT_INTERRUPT_FLAG_BIT] = flags[1];
      sts_word[xcb_pkg::STS_HSE_BIT]  = flags[0];
   end

   // ----------------------------------------------------------------
   // Notification, ring control, context pointer, configure
   // ----------------------------------------------------------------
   logic [31:0] note_q;
   logic [31:0] crcr_lo_q;
   logic [31:0] crcr_hi_q;
   logic [31:0] dcba_lo_q;
   logic [31:0] dcba_hi_q;
   logic [31:0] config_q;
   logic        ring_run_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         note_q   <= xcb_pkg::ZERO_WORD;
         config_q <= xcb_pkg::ZERO_WORD;
      end else begin
         if (wr_note) begin
            note_q <= merge(note_q, bus_req_i.wdata, bus_req_i.be, xcb_pkg::NOTE_MASK);
         end
         if (wr_config) begin
            config_q <= merge(config_q, bus_req_i.wdata, bus_req_i.be,
                              xcb_pkg::CONFIG_MASK);
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crcr_lo_q <= xcb_pkg::ZERO_WORD;
         crcr_hi_q <= xcb_pkg::ZERO_WORD;
      end else begin
         if (wr_crcr_lo) begin
            // Ring running bit and bits 5:4 are not writable
            crcr_lo_q <= merge(crcr_lo_q, bus_req_i.wdata, bus_req_i.be,
                               xcb_pkg::CRCR_RW_MASK);
         end
         if (wr_crcr_hi) begin
            crcr_hi_q <= merge(crcr_hi_q, bus_req_i.wdata, bus_req_i.be, xcb_pkg::HI_MASK);
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ring_run_q <= 1'b0;
      end else begin
         ring_run_q <= hw_i.ring_running;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dcba_lo_q <= xcb_pkg::ZERO_WORD;
         dcba_hi_q <= xcb_pkg::ZERO_WORD;
      end else begin
         if (wr_dcba_lo) begin
            dcba_lo_q <= merge(dcba_lo_q, bus_req_i.wdata, bus_req_i.be,
                               xcb_pkg::PTR_LO_MASK);
         end
         if (wr_dcba_hi) begin
            dcba_hi_q <= merge(dcba_hi_q, bus_req_i.wdata, bus_req_i.be, xcb_pkg::HI_MASK);
         end
      end
   end

   assign note_en_o       = note_q[15:0];
   assign config_o        = config_q[7:0];
   assign ctx_array_ptr_o = {dcba_hi_q, dcba_lo_q};
   assign ring_ctl_o      = {crcr_hi_q, crcr_lo_q[31:4], ring_run_q, crcr_lo_q[2:0]};

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   logic [31:0] rd_data_q;
   logic        rd_valid_q;
   logic [31:0] crcr_lo_rd;

   assign crcr_lo_rd = {crcr_lo_q[31:4], ring_run_q, crcr_lo_q[2:0]};

   always_comb begin
      rd_mux = xcb_pkg::ZERO_WORD;
      if (bus_req_i.addr == xcb_pkg::CAP_DB_OFF) begin
         rd_mux = xcb_pkg::DB_VALUE;
      end else if (bus_req_i.addr == xcb_pkg::CAP_RT_OFF) begin
         rd_mux = xcb_pkg::RT_VALUE;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_CMD)) begin
         rd_mux = cmd_q & xcb_pkg::CMD_MASK;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_STS)) begin
         rd_mux = sts_word;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_PAGE)) begin
         rd_mux = xcb_pkg::PAGE_VALUE;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_NOTE)) begin
         rd_mux = note_q;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_CRCR_LO)) begin
         rd_mux = crcr_lo_rd;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_CRCR_HI)) begin
         rd_mux = crcr_hi_q;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_DCBA_LO)) begin
         rd_mux = dcba_lo_q;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_DCBA_HI)) begin
         rd_mux = dcba_hi_q;
      end else if (op_at(bus_req_i.addr, xcb_pkg::OP_CONFIG)) begin
         rd_mux = config_q;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_q  <= xcb_pkg::ZERO_WORD;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= bus_req_i.rd;
         if (bus_req_i.rd) begin
            rd_data_q <= rd_mux;
         end
      end
   end

   assign rd_data_o  = rd_data_q;
   assign rd_valid_o = rd_valid_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic rd_db;
   logic rd_rt;
   logic rd_page;
   logic rd_sts;
   logic rd_cmd;

   assign rd_db   = bus_req_i.rd && (bus_req_i.addr == xcb_pkg::CAP_DB_OFF);
   assign rd_rt   = bus_req_i.rd && (bus_req_i.addr == xcb_pkg::CAP_RT_OFF);
   assign rd_page = bus_req_i.rd && op_at(bus_req_i.addr, xcb_pkg::OP_PAGE);
   assign rd_sts  = bus_req_i.rd && op_at(bus_req_i.addr, xcb_pkg::OP_STS);
   assign rd_cmd  = bus_req_i.rd && op_at(bus_req_i.addr, xcb_pkg::OP_CMD);

   chk_doorbell_const: assert property (rd_db |=> rd_valid_o && rd_data_o == 32'h5C0)
      else $error("doorbell offset read wrong");

   chk_runtime_const: assert property (rd_rt |=> rd_valid_o && rd_data_o == 32'h4A0)
      else $error("runtime offset read wrong");

   chk_op_base_shift: assert property (
      bus_req_i.wr && bus_req_i.addr == 16'h0000 |=> cmd_q == $past(cmd_q))
      else $error("command written without capability length offset");

   chk_cmd_write_read: assert property (
      wr_cmd && bus_req_i.be == 4'hF ##1 rd_cmd
      |=> rd_data_o == ($past(bus_req_i.wdata, 2) & 32'h00000F8F))
      else $error("command readback mismatch");

   chk_port_reads_zero: assert property (bus_req_i.rd && port_hit |=> rd_data_o == 32'h0)
      else $error("port space read not zero");

   chk_status_reserved: assert property (
      rd_sts |=> (rd_data_o & 32'hFFFFE0E2) == 32'h00000000)
      else $error("status reserved bits not zero");

   chk_status_flag_rise: assert property (
      hw_i.port_change_evt ##1 rd_sts |=> rd_data_o[4])
      else $error("port change flag not set");

   chk_page_const: assert property (rd_page |=> rd_data_o == 32'h00000001)
      else $error("page size read wrong");

   chk_ro_write_inert: assert property (
      bus_req_i.wr
      && (bus_req_i.addr == xcb_pkg::CAP_DB_OFF || op_at(bus_req_i.addr, xcb_pkg::OP_PAGE))
      |=> $stable(cmd_q) && $stable(note_q) && $stable(config_q) && $stable(crcr_lo_q))
      else $error("read-only write changed state");

   chk_status_reset: assert property (
      $rose(rst_n_i) |-> sts_word == 32'h00000801)
      else $error("status reset value wrong");

   cov_cmd_run: cover property (wr_cmd && bus_req_i.wdata[0] && bus_req_i.be[0]);
   cov_sts_clear: cover property (wr_sts && flag_clr != '0);
   cov_port_read: cover property (bus_req_i.rd && port_hit);

endmodule

`default_nettype wire

//--- verification/test_xcb_reg_bank.sv
// Self-checking bench for the capability and operational register bank
`timescale 1ns/1ps
`default_nettype none

module test_xcb_reg_bank;
   logic                 ref_clk_i;
   logic                 rst_n_i;
   xcb_pkg::xcb_req_type bus_req_i;
   xcb_pkg::xcb_hw_type  hw_i;
   logic [31:0]          rd_data_o;
   logic                 rd_valid_o;
   xcb_pkg::xcb_cmd_type cmd_o;
   logic [15:0]          note_en_o;
   logic [63:0]          ring_ctl_o;
   logic [63:0]          ctx_array_ptr_o;
   logic [7:0]           config_o;
   int                   bad_count;
   int                   comparisons;
   logic [31:0]          seed;
   logic [31:0]          wd;
   logic [31:0]          fb;
   logic [31:0]          cmd_exp;
   logic [3:0]           be;
   logic [15:0]          tab_a [6];
   logic [31:0]          tab_m [6];
   logic [31:0]          tab_v [6];
   logic [15:0]          res_a [6];

   xcb_reg_bank dut (
      .ref_clk_i       (ref_clk_i),
      .rst_n_i         (rst_n_i),
      .bus_req_i       (bus_req_i),
      .hw_i            (hw_i),
      .rd_data_o       (rd_data_o),
      .rd_valid_o      (rd_valid_o),
      .cmd_o           (cmd_o),
      .note_en_o       (note_en_o),
      .ring_ctl_o      (ring_ctl_o),
      .ctx_array_ptr_o (ctx_array_ptr_o),
      .config_o        (config_o)
   );

   always #50 ref_clk_i = ~ref_clk_i;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] byte_mask(input logic [3:0] b);
      return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
      @(negedge ref_clk_i);
      bus_req_i = '{rd: 1'b0, wr: 1'b1, addr: a, be: b, wdata: d};
      @(negedge ref_clk_i);
      bus_req_i.wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] want);
      int n;
      @(negedge ref_clk_i);
      bus_req_i.addr = a;
      bus_req_i.rd = 1'b1;
      @(negedge ref_clk_i);
      bus_req_i.rd = 1'b0;
      n = 0;
      while (rd_valid_o !== 1'b1 && n < 4) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (n == 4) begin
         bad_count++;
         $display("Error at %0t: no read answer from %h", $time, a);
         summarize();
      end else begin
         check(rd_data_o, want);
      end
   endtask

   task automatic wr_rd(input logic [15:0] a, input logic [31:0] d, input logic [31:0] want);
      @(negedge ref_clk_i);
      bus_req_i = '{rd: 1'b0, wr: 1'b1, addr: a, be: 4'hF, wdata: d};
      @(negedge ref_clk_i);
      bus_req_i = '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: d};
      @(negedge ref_clk_i);
      bus_req_i.rd = 1'b0;
      check({31'h00000000, rd_valid_o}, 32'h00000001);
      check(rd_data_o, want);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      rst_n_i = 1'b0;
      bus_req_i = '0;
      hw_i = '0;
      hw_i.not_ready = 1'b1;
      hw_i.halted = 1'b1;
      bad_count = 0;
      comparisons = 0;
      seed = 32'hB264;
      tab_a = '{16'h0034, 16'h0058, 16'h0050, 16'h0054, 16'h0038, 16'h003C};
      tab_m = '{32'h0000FFFF, 32'h000000FF, 32'hFFFFFFC0, 32'hFFFFFFFF, 32'hFFFFFFC7,
                32'hFFFFFFFF};
      res_a = '{16'h002C, 16'h0040, 16'h005C, 16'h041C, 16'h0420, 16'h049C};
      repeat (8) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      check({23'h000000, cmd_o}, 32'h00000000);
      rd_chk(16'h0024, 32'h00000801);
      rd_chk(16'h0020, 32'h00000000);
      rd_chk(16'h0014, 32'h000005C0);
      rd_chk(16'h0018, 32'h000004A0);
      rd_chk(16'h0028, 32'h00000001);
      reg_wr(16'h0014, 32'hFFFFFFFF, 4'hF);
      reg_wr(16'h0018, 32'h00000000, 4'hF);
      reg_wr(16'h0028, 32'hFFFFFFFE, 4'hF);
      rd_chk(16'h0014, 32'h000005C0);
      rd_chk(16'h0018, 32'h000004A0);
      rd_chk(16'h0028, 32'h00000001);
      // Command word: all ones first, then random data; full byte enables for the first three writes, random after
      cmd_exp = 32'h00000000;
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         wd = (i == 0) ? 32'hFFFFFFFF : seed;
         seed = lfsr(seed);
         be = (i < 3) ? 4'hF : seed[3:0];
         reg_wr(16'h0020, wd, be);
         cmd_exp = (cmd_exp & ~byte_mask(be)) | (wd & byte_mask(be) & 32'h00000F8F);
         rd_chk(16'h0020, cmd_exp);
         check({23'h000000, cmd_o},
               {23'h000000, cmd_exp[11:7], cmd_exp[3:0]});
      end
      // Write followed at once by a read of the same word
      seed = lfsr(seed);
      cmd_exp = seed & 32'h00000F8F;
      wr_rd(16'h0020, seed, cmd_exp);
      // Read-only state follows the core, writes of ones are ignored
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         @(negedge ref_clk_i);
         hw_i = '0;
         hw_i.controller_error = seed[0];
         hw_i.not_ready = seed[1];
         hw_i.restore_busy = seed[2];
         hw_i.save_busy = seed[3];
         hw_i.halted = seed[4];
         reg_wr(16'h0024, 32'hFFFFFBE3, 4'hF);
         rd_chk(16'h0024, {19'h00000, seed[0], seed[1], 1'b0, seed[2], seed[3],
                           7'h00, seed[4]});
      end
      // Sticky flags: set by a pulse, kept by reads and zero writes, cleared by one
      @(negedge ref_clk_i);
      hw_i = '0;
      for (int k = 0; k < 4; k++) begin
         fb = (k == 3) ? 32'h00000400 : (32'h00000004 << k);
         @(negedge ref_clk_i);
         hw_i[6+k] = 1'b1;
         @(negedge ref_clk_i);
         hw_i[6+k] = 1'b0;
         rd_chk(16'h0024, fb);
         reg_wr(16'h0024, ~fb, 4'hF);
         rd_chk(16'h0024, fb);
         reg_wr(16'h0024, fb, 4'hF);
         rd_chk(16'h0024, 32'h00000000);
      end
      // A new event in the cycle of a clear keeps the flag, read straight after
      @(negedge ref_clk_i);
      hw_i.port_change_evt = 1'b1;
      bus_req_i = '{rd: 1'b0, wr: 1'b1, addr: 16'h0024, be: 4'hF, wdata: 32'h00000010};
      @(negedge ref_clk_i);
      hw_i.port_change_evt = 1'b0;
      bus_req_i = '{rd: 1'b1, wr: 1'b0, addr: 16'h0024, be: 4'hF, wdata: 32'h00000010};
      @(negedge ref_clk_i);
      bus_req_i.rd = 1'b0;
      check({31'h00000000, rd_valid_o}, 32'h00000001);
      check(rd_data_o, 32'h00000010);
      // Operational map relative to the operational base
      for (int j = 0; j < 6; j++) begin
         seed = lfsr(seed);
         tab_v[j] = seed & tab_m[j];
         reg_wr(tab_a[j], seed, 4'hF);
         rd_chk(tab_a[j], tab_v[j]);
      end
      check({16'h0000, note_en_o}, {16'h0000, tab_v[0][15:0]});
      check({24'h000000, config_o}, {24'h000000, tab_v[1][7:0]});
      check(ctx_array_ptr_o[31:0], tab_v[2]);
      check(ctx_array_ptr_o[63:32], tab_v[3]);
      check(ring_ctl_o[31:0], tab_v[4]);
      check(ring_ctl_o[63:32], tab_v[5]);
      // Ring running state shows in bit 3 of the ring control word
      hw_i.ring_running = 1'b1;
      rd_chk(16'h0038, tab_v[4] | 32'h00000008);
      check(ring_ctl_o[31:0], tab_v[4] | 32'h00000008);
      hw_i.ring_running = 1'b0;
      // Reserved and port space read zero and keep no state
      for (int j = 0; j < 6; j++) begin
         reg_wr(res_a[j], 32'hFFFFFFFF, 4'hF);
         rd_chk(res_a[j], 32'h00000000);
      end
      rd_chk(16'h0020, cmd_exp);
      rd_chk(16'h0034, tab_v[0]);
      // Second reset in mid-run
      @(negedge ref_clk_i);
      rst_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      rd_chk(16'h0020, 32'h00000000);
      rd_chk(16'h0024, 32'h00000000);
      summarize();
   end
endmodule

`default_nettype wire
